// ---- verilog/pcicfg_pkg.sv ----
// Purpose: constants for the configuration header register bank
// Assumes: 32-bit dword header, byte offsets are byte addresses
// Notes:   identity values live as module parameters, not here
//
// Functional notes
// - command all zero disconnects except configuration and target abort
// - unimplemented command bits read zero
// - detected parity error set regardless of enable
// - signaled system error set on SERR drive
// - master abort sets received master abort
// - target abort sets received target abort
// - address parity error: target abort, flag
// - medium DEVSEL timing, field reads 01
// - parity reported only with response enabled
// - fast back-to-back bit reads one
// - SERR driven only when enabled
// - PERR driven only when enabled
// - no bus request without master enable
// - memory decode only with memory enable
// - latency count expiry ends burst after GNT
// - header type byte reads zero
// - host writes base, device decodes there
// - low base bits fixed read-only 0x008
// - class code reads multimedia video
// - first dword: maker and part codes
// - revision byte in class dword
// - write one clears flag, reset clears
// - bad writes discarded, reserved reads zero
// - accept only IDSEL high, AD[1:0] zero
// - type 0 only, AD[7:2] decode, ignore AD[10:8]
package pcicfg_pkg;
   // dword byte offsets
   localparam logic [7:0]  OFS_IDENT   = 8'h00;
   localparam logic [7:0]  OFS_CMDSTS  = 8'h04;
   localparam logic [7:0]  OFS_CLASS   = 8'h08;
   localparam logic [7:0]  OFS_LATHDR  = 8'h0C;
   localparam logic [7:0]  OFS_MEMBASE = 8'h10;
   // command bit positions
   localparam int          CMD_MEM     = 1;
   localparam int          CMD_MST     = 2;
   localparam int          CMD_PERR    = 6;
   localparam int          CMD_SERR    = 8;
   // status flag indices inside the flag bank
   localparam int          FLAG_N      = 6;
   localparam int          FL_DPR      = 0;  // status bit 24
   localparam int          FL_STA      = 1;  // status bit 27
   localparam int          FL_RTA      = 2;  // status bit 28
   localparam int          FL_RMA      = 3;  // status bit 29
   localparam int          FL_SSE      = 4;  // status bit 30
   localparam int          FL_DPE      = 5;  // status bit 31
   // fixed read-only fields
   localparam logic [1:0]  DEVSEL_MED  = 2'h1;
   localparam logic        FB2B_CAP    = 1'h1;
   localparam logic [23:0] CLASS_CODE  = 24'h040000;
   localparam logic [7:0]  HDR_TYPE    = 8'h00;
   localparam logic [11:0] BASE_LOW    = 12'h008;
   localparam int          BASE_LSB    = 12;
   // reset values
   localparam logic [15:0] CMD_RST     = 16'h0000;
   localparam logic [7:0]  LAT_RST     = 8'h00;
   localparam logic [19:0] BASE_RST    = 20'h00000;
   localparam logic [31:0] RDATA_RST   = 32'h00000000;
   // latency timer states
   typedef enum logic [2:0] {
      LT_IDLE = 3'b001,
      LT_RUN  = 3'b010,
      LT_DONE = 3'b100
   } pcicfg_lat_t;
endpackage : pcicfg_pkg

// ---- verilog/pcicfg_w1c_flags.sv ----
// Purpose: bank of sticky status flags, set by hardware, cleared by writing one
// Assumes: set and clear are single-cycle terms on sys_clk
// Notes:   a set in the clear cycle wins so no event is lost
module pcicfg_w1c_flags #(
   parameter int WIDTH = 6
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // hardware events and software clears
   input  wire logic [WIDTH-1:0] set_pulse,
   input  wire logic [WIDTH-1:0] clr_mask,
   // flag state
   output logic      [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] flags_d;   // next flag value
   logic [WIDTH-1:0] flags_q;   // held flags

   // refuse an empty bank
   if (WIDTH < 1) begin : g_bad_width
      $error("pcicfg_w1c_flags: WIDTH must be at least 1");
   end

   always_comb begin
      flags_d = (flags_q & ~clr_mask) | set_pulse;
   end

   // flags reset to zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;
endmodule : pcicfg_w1c_flags

// ---- verilog/pcicfg_header_regs.sv ----
// Purpose: predefined configuration header of a single-function capture device
// Assumes: bus front end on sys_clk decodes cycles into the strobes below
// Notes:   byte enables are active high here; events are one-cycle pulses
module pcicfg_header_regs #(
   parameter logic [15:0] MAKER_CODE = 16'h1AB5,  // arbitrary value
   parameter logic [15:0] PART_CODE  = 16'h2C47,  // arbitrary value
   parameter logic [7:0]  REVISION   = 8'h5A,     // arbitrary value
   parameter int          LAT_W      = 8
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // configuration access
   input  wire logic        cfg_req,
   input  wire logic        cfg_idsel,
   input  wire logic        cfg_type1,
   input  wire logic        cfg_we,
   input  wire logic [10:0] cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic             cfg_ack,
   output logic [31:0]      cfg_rdata,
   // memory target decode
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             mem_hit,
   // master side
   input  wire logic        mst_want,
   input  wire logic        mst_burst,
   input  wire logic        mst_gnt_n,
   input  wire logic        mst_read,
   output logic             bus_req,
   output logic             lat_terminate,
   // bus events
   input  wire logic        addr_perr,
   input  wire logic        data_perr,
   input  wire logic        mst_abort,
   input  wire logic        tgt_abort_rcvd,
   input  wire logic        tgt_perr_seen,
   input  wire logic        serr_cause,
   output logic             serr_drive,
   output logic             perr_drive,
   output logic             tgt_abort_out,
   // command view
   output logic             mem_space_en,
   output logic             bus_master_en
);
   ////////////////////////////////////////////////////////////////////////////
   // functions

   // merge write data into a field under byte enables
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : be_merge

   // refuse a latency width the header field cannot hold
   if (LAT_W != 8) begin : g_bad_lat
      $error("pcicfg_header_regs: LAT_W must be 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [15:0]      cmd_q, cmd_d;        // command field
   logic [LAT_W-1:0] lat_q, lat_d;        // latency count
   logic [19:0]      base_q, base_d;      // base address upper bits
   logic             ack_q, ack_d;        // access answer
   logic [31:0]      rdata_q, rdata_d;    // read data
   logic             hit_q, hit_d;        // memory claim
   logic             breq_q, breq_d;      // bus request
   logic             serr_q, serr_d;      // SERR drive
   logic             perr_q, perr_d;      // PERR drive
   logic             tab_q, tab_d;        // target abort
   logic             term_q, term_d;      // latency termination
   logic [LAT_W-1:0] cnt_q, cnt_d;        // latency countdown
   pcicfg_pkg::pcicfg_lat_t lt_q, lt_d;   // latency state
   logic [pcicfg_pkg::FLAG_N-1:0] fl_set;  // flag set terms
   logic [pcicfg_pkg::FLAG_N-1:0] fl_clr;  // flag clear mask
   logic [pcicfg_pkg::FLAG_N-1:0] flags;   // sticky flags
   logic             take;                // access accepted
   logic             wr;                  // accepted write
   logic [7:0]       ofs;                 // byte offset
   logic [15:0]      status;              // status half
   logic [31:0]      cmd_merged;          // command after write
   logic [31:0]      lat_merged;          // latency after write
   logic [31:0]      base_merged;         // base after write

   ////////////////////////////////////////////////////////////////////////////
   // access decode

   always_comb begin
      take = cfg_req & cfg_idsel & ~cfg_type1 & (cfg_addr[1:0] == 2'h0);
      wr   = take & cfg_we;
      ofs  = {cfg_addr[7:2], 2'h0};
   end

   // status half, fixed fields among the flags
   // medium DEVSEL field
   always_comb begin
      status = {flags[pcicfg_pkg::FL_DPE], flags[pcicfg_pkg::FL_SSE],
                flags[pcicfg_pkg::FL_RMA], flags[pcicfg_pkg::FL_RTA],
                flags[pcicfg_pkg::FL_STA], pcicfg_pkg::DEVSEL_MED,
                flags[pcicfg_pkg::FL_DPR], pcicfg_pkg::FB2B_CAP, 7'h00};
   end

   ////////////////////////////////////////////////////////////////////////////
   // writable registers and read mux

   // byte-enable merges, only meaningful bits kept
   always_comb begin
      cmd_merged  = be_merge({16'h0000, cmd_q}, cfg_wdata, cfg_be);
      lat_merged  = be_merge({16'h0000, lat_q, 8'h00}, cfg_wdata, cfg_be);
      base_merged = be_merge({base_q, pcicfg_pkg::BASE_LOW}, cfg_wdata, cfg_be);
   end

   // register writes and answer
   always_comb begin
      cmd_d   = cmd_q;
      lat_d   = lat_q;
      base_d  = base_q;
      fl_clr  = '0;
      ack_d   = take;
      rdata_d = rdata_q;
      if (wr) begin
         case (ofs)
            pcicfg_pkg::OFS_CMDSTS: begin
               cmd_d = '0;
               cmd_d[pcicfg_pkg::CMD_MEM]  = cmd_merged[pcicfg_pkg::CMD_MEM];
               cmd_d[pcicfg_pkg::CMD_MST]  = cmd_merged[pcicfg_pkg::CMD_MST];
               cmd_d[pcicfg_pkg::CMD_PERR] = cmd_merged[pcicfg_pkg::CMD_PERR];
               cmd_d[pcicfg_pkg::CMD_SERR] = cmd_merged[pcicfg_pkg::CMD_SERR];
               if (cfg_be[3]) begin
                  fl_clr = {cfg_wdata[31:27], cfg_wdata[24]};
               end
            end
            pcicfg_pkg::OFS_LATHDR: lat_d = lat_merged[15:8];
            pcicfg_pkg::OFS_MEMBASE: base_d = base_merged[31:12];
            default: ;
         endcase
      end
      // read data, reserved offsets give zero
      if (take && !cfg_we) begin
         case (ofs)
            pcicfg_pkg::OFS_IDENT: rdata_d = {PART_CODE, MAKER_CODE};
            pcicfg_pkg::OFS_CMDSTS: rdata_d = {status, cmd_q};
            pcicfg_pkg::OFS_CLASS: rdata_d = {pcicfg_pkg::CLASS_CODE, REVISION};
            pcicfg_pkg::OFS_LATHDR: rdata_d = {8'h00, pcicfg_pkg::HDR_TYPE, lat_q, 8'h00};
            pcicfg_pkg::OFS_MEMBASE: rdata_d = {base_q, pcicfg_pkg::BASE_LOW};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // register the header state
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cmd_q   <= pcicfg_pkg::CMD_RST;
         lat_q   <= pcicfg_pkg::LAT_RST;
         base_q  <= pcicfg_pkg::BASE_RST;
         ack_q   <= 1'b0;
         rdata_q <= pcicfg_pkg::RDATA_RST;
      end else begin
         cmd_q   <= cmd_d;
         lat_q   <= lat_d;
         base_q  <= base_d;
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus-side effects of the command field

   // gated responses; a zero command silences all but the target abort
   always_comb begin
      hit_d  = mem_req & cmd_q[pcicfg_pkg::CMD_MEM] &
               (mem_addr[31:pcicfg_pkg::BASE_LSB] == base_q);
      breq_d = mst_want & cmd_q[pcicfg_pkg::CMD_MST];
      serr_d = serr_cause & cmd_q[pcicfg_pkg::CMD_SERR];
      perr_d = data_perr & cmd_q[pcicfg_pkg::CMD_PERR];
      tab_d  = addr_perr;
   end

   // status events feeding the flag bank
   always_comb begin
      fl_set = '0;
      fl_set[pcicfg_pkg::FL_DPE] = addr_perr | data_perr;
      fl_set[pcicfg_pkg::FL_SSE] = serr_d;
      fl_set[pcicfg_pkg::FL_RMA] = mst_abort;
      fl_set[pcicfg_pkg::FL_RTA] = tgt_abort_rcvd;
      fl_set[pcicfg_pkg::FL_STA] = addr_perr;
      fl_set[pcicfg_pkg::FL_DPR] = cmd_q[pcicfg_pkg::CMD_PERR] &
                                   ((perr_d & mst_read) | (tgt_perr_seen & ~mst_read));
   end

   pcicfg_w1c_flags #(
      .WIDTH     (pcicfg_pkg::FLAG_N)
   ) u_flags (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .set_pulse (fl_set),
      .clr_mask  (fl_clr),
      .flags     (flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // latency timer

   // load on burst start, count down, end after GNT goes
   always_comb begin
      lt_d   = lt_q;
      cnt_d  = cnt_q;
      term_d = 1'b0;
      case (lt_q)
         pcicfg_pkg::LT_IDLE: begin
            if (mst_burst) begin
               lt_d  = pcicfg_pkg::LT_RUN;
               cnt_d = lat_q;
            end
         end
         pcicfg_pkg::LT_RUN: begin
            if (!mst_burst) begin
               lt_d = pcicfg_pkg::LT_IDLE;
            end else if (cnt_q == '0) begin
               lt_d = pcicfg_pkg::LT_DONE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         pcicfg_pkg::LT_DONE: begin
            term_d = mst_burst & mst_gnt_n;
            if (!mst_burst) begin
               lt_d = pcicfg_pkg::LT_IDLE;
            end
         end
         default: lt_d = pcicfg_pkg::LT_IDLE;
      endcase
   end

   // register outputs and timer
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hit_q  <= 1'b0;
         breq_q <= 1'b0;
         serr_q <= 1'b0;
         perr_q <= 1'b0;
         tab_q  <= 1'b0;
         term_q <= 1'b0;
         cnt_q  <= '0;
         lt_q   <= pcicfg_pkg::LT_IDLE;
      end else begin
         hit_q  <= hit_d;
         breq_q <= breq_d;
         serr_q <= serr_d;
         perr_q <= perr_d;
         tab_q  <= tab_d;
         term_q <= term_d;
         cnt_q  <= cnt_d;
         lt_q   <= lt_d;
      end
   end

   // outputs straight from flip-flops
   assign cfg_ack       = ack_q;
   assign cfg_rdata     = rdata_q;
   assign mem_hit       = hit_q;
   assign bus_req       = breq_q;
   assign lat_terminate = term_q;
   assign serr_drive    = serr_q;
   assign perr_drive    = perr_q;
   assign tgt_abort_out = tab_q;
   assign mem_space_en  = cmd_q[pcicfg_pkg::CMD_MEM];
   assign bus_master_en = cmd_q[pcicfg_pkg::CMD_MST];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   chk_cfg_ignore: assert property (@(posedge sys_clk) disable iff (srst)
      (cfg_req && (!cfg_idsel || cfg_addr[1:0] != 2'h0)) |=> !cfg_ack)
      else $error("access without IDSEL or aligned address answered");

   chk_hit_gate: assert property (@(posedge sys_clk) disable iff (srst)
      mem_hit |-> $past(cmd_q[pcicfg_pkg::CMD_MEM]) && $past(mem_req))
      else $error("memory claimed while memory decode disabled");

   chk_breq_gate: assert property (@(posedge sys_clk) disable iff (srst)
      bus_req |-> $past(cmd_q[pcicfg_pkg::CMD_MST]))
      else $error("bus requested without master enable");

   chk_serr_flag: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(serr_drive) |-> flags[pcicfg_pkg::FL_SSE])
      else $error("SERR driven without status flag");

   chk_perr_gate: assert property (@(posedge sys_clk) disable iff (srst)
      (data_perr && !cmd_q[pcicfg_pkg::CMD_PERR]) |=> !perr_drive ##0
      flags[pcicfg_pkg::FL_DPE])
      else $error("PERR driven while disabled or parity error lost");

   chk_tabort_flag: assert property (@(posedge sys_clk) disable iff (srst)
      addr_perr |=> tgt_abort_out && flags[pcicfg_pkg::FL_STA])
      else $error("address parity error without target abort");

   chk_fixed_read: assert property (@(posedge sys_clk) disable iff (srst)
      (take && !cfg_we && ofs == pcicfg_pkg::OFS_MEMBASE) |=>
      cfg_ack && cfg_rdata[11:0] == 12'h008)
      else $error("base low bits not fixed");

   chk_cmd_zero: assert property (@(posedge sys_clk) disable iff (srst)
      (take && !cfg_we && ofs == pcicfg_pkg::OFS_CMDSTS) |=>
      cfg_rdata[15:9] == 7'h00 && cfg_rdata[7] == 1'b0 && cfg_rdata[5:3] == 3'h0 &&
      cfg_rdata[0] == 1'b0 && cfg_rdata[26:25] == 2'h1 && cfg_rdata[23] == 1'b1)
      else $error("unimplemented command bit or fixed status field wrong");

   chk_lat_term: assert property (@(posedge sys_clk) disable iff (srst)
      lat_terminate |-> $past(lt_q == pcicfg_pkg::LT_DONE) && $past(mst_gnt_n))
      else $error("termination before expiry or with GNT held");
endmodule : pcicfg_header_regs

// ---- testbench/pcicfg_host_model.sv ----
// Purpose: host bridge model issuing configuration dword cycles
// Assumes: one strobe cycle per dword, answer within a few cycles
// Notes:   released lines show inverted junk so stale values never pass
module pcicfg_host_model (
   // clock
   input  wire logic        sys_clk,
   // request lines
   output logic             cfg_req,
   output logic             cfg_idsel,
   output logic             cfg_type1,
   output logic             cfg_we,
   output logic [10:0]      cfg_addr,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata,
   // answer lines
   input  wire logic        cfg_ack,
   input  wire logic [31:0] cfg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle bus at time zero
   initial begin
      cfg_req   = 1'b0;
      cfg_idsel = 1'b0;
      cfg_type1 = 1'b0;
      cfg_we    = 1'b0;
      cfg_addr  = 11'h7FF;
      cfg_be    = 4'h0;
      cfg_wdata = 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one access; the answer is looked for over three cycles
   // host selects device and sets address
   task automatic access(input logic we, input logic [10:0] addr, input logic [3:0] be,
                         input logic [31:0] wdata, input logic idsel, input logic type1,
                         output logic acked, output logic [31:0] rdata);
      acked = 1'b0;
      rdata = 32'h00000000;
      @(posedge sys_clk);
      #1;
      cfg_req   = 1'b1;
      cfg_idsel = idsel;
      cfg_type1 = type1;
      cfg_we    = we;
      cfg_addr  = addr;
      cfg_be    = be;
      cfg_wdata = wdata;
      @(posedge sys_clk);
      #1;
      // released: strobe down, data lines toggled
      cfg_req   = 1'b0;
      cfg_idsel = 1'b0;
      cfg_addr  = ~cfg_addr;
      cfg_wdata = ~cfg_wdata;
      repeat (3) begin
         if (cfg_ack === 1'b1 && acked === 1'b0) begin
            acked = 1'b1;
            rdata = cfg_rdata;
         end
         @(posedge sys_clk);
         #1;
      end
   endtask : access
endmodule : pcicfg_host_model

// ---- testbench/pcicfg_header_regs_bench.sv ----
// Purpose: self-checking bench of the configuration header bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   identity parameters set here with arbitrary values
module pcicfg_header_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] MK = 16'h3D21;  // arbitrary value
   localparam logic [15:0] PT = 16'h4E72;  // arbitrary value
   localparam logic [7:0]  RV = 8'h6B;     // arbitrary value
   // design wires
   logic        sys_clk, srst, cfg_req, cfg_idsel, cfg_type1, cfg_we, cfg_ack;
   logic [10:0] cfg_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, mem_addr;
   logic        mem_req, mem_hit, mst_want, mst_burst, mst_gnt_n, mst_read;
   logic        bus_req, lat_terminate, serr_drive, perr_drive, tgt_abort_out;
   logic        mem_space_en, bus_master_en;
   logic [5:0]  evt;  // addr_perr,data_perr,mst_abort,tgt_abort,tgt_perr,serr_cause
   int          n_fail, checks_done;

   pcicfg_header_regs #(.MAKER_CODE(MK), .PART_CODE(PT), .REVISION(RV), .LAT_W(8))
   pcicfg_header_regs_i (.sys_clk(sys_clk), .srst(srst), .cfg_req(cfg_req),
      .cfg_idsel(cfg_idsel), .cfg_type1(cfg_type1), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_hit(mem_hit), .mst_want(mst_want),
      .mst_burst(mst_burst), .mst_gnt_n(mst_gnt_n), .mst_read(mst_read), .bus_req(bus_req),
      .lat_terminate(lat_terminate), .addr_perr(evt[5]), .data_perr(evt[4]),
      .mst_abort(evt[3]), .tgt_abort_rcvd(evt[2]), .tgt_perr_seen(evt[1]),
      .serr_cause(evt[0]), .serr_drive(serr_drive), .perr_drive(perr_drive),
      .tgt_abort_out(tgt_abort_out), .mem_space_en(mem_space_en),
      .bus_master_en(bus_master_en));

   pcicfg_host_model pcicfg_host_model_i (.sys_clk(sys_clk), .cfg_req(cfg_req),
      .cfg_idsel(cfg_idsel), .cfg_type1(cfg_type1), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

   ////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // read must be answered with the expected dword
   task automatic rd(input logic [10:0] a, input logic [31:0] exp, input string what);
      logic        ok;
      logic [31:0] d;
      pcicfg_host_model_i.access(1'b0, a, 4'hF, 32'h0, 1'b1, 1'b0, ok, d);
      chk({what, " ack"}, 32'h1, {31'h0, ok});
      chk(what, exp, d);
   endtask : rd

   task automatic wr(input logic [10:0] a, input logic [3:0] be, input logic [31:0] d);
      logic        ok;
      logic [31:0] r;
      pcicfg_host_model_i.access(1'b1, a, be, d, 1'b1, 1'b0, ok, r);
      chk("write ack", 32'h1, {31'h0, ok});
   endtask : wr

   // cycle that must be ignored: no answer at all
   task automatic nak(input logic we, input logic [10:0] a, input logic ids, input logic t1);
      logic        ok;
      logic [31:0] r;
      pcicfg_host_model_i.access(we, a, 4'hF, 32'hFFFFFFFF, ids, t1, ok, r);
      chk("ignored cycle ack", 32'h0, {31'h0, ok});
   endtask : nak

   // one event pulse; gathers {serr,perr,target abort} drives over three cycles
   task automatic fire(input logic [5:0] e, input logic [2:0] exp, input string what);
      logic [2:0] seen;
      seen = 3'h0;
      @(posedge sys_clk);
      #1;
      evt = e;
      @(posedge sys_clk);
      #1;
      evt = 6'h00;
      repeat (3) begin
         seen = seen | {serr_drive, perr_drive, tgt_abort_out};
         @(posedge sys_clk);
         #1;
      end
      chk(what, {29'h0, exp}, {29'h0, seen});
   endtask : fire

   // sample a design output over n cycles, reporting whether it was ever high
   task automatic watch(ref logic s, input int n, output logic hi);
      hi = 1'b0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         hi = hi | (s === 1'b1);
      end
   endtask : watch

   ////////////////////////////////////////////////////////////////////////////
   // fixed fields, reserved places and ignored cycles
   task automatic test_fixed();
      rd(11'h000, {PT, MK}, "identity");
      rd(11'h004, 32'h02800000, "status reset");
      rd(11'h008, {24'h040000, RV}, "class rev");
      rd(11'h00C, 32'h00000000, "latency reset");
      rd(11'h010, 32'h00000008, "base reset");
      rd(11'h014, 32'h00000000, "reserved");
      rd(11'h108, {24'h040000, RV}, "high bits");
      nak(1'b1, 11'h004, 1'b0, 1'b0);
      nak(1'b1, 11'h005, 1'b1, 1'b0);
      nak(1'b1, 11'h004, 1'b1, 1'b1);
      wr(11'h000, 4'hF, 32'h00000000);
      rd(11'h004, 32'h02800000, "cmd untouched");
      rd(11'h000, {PT, MK}, "identity kept");
      $display("test_fixed done");
   endtask : test_fixed

   // command bits, decode, mastering and the all-zero command
   task automatic test_command();
      logic hi;
      wr(11'h004, 4'h3, 32'hFFFFFFFF);
      rd(11'h004, 32'h02800146, "cmd mask");
      chk("enables", 32'h3, {30'h0, bus_master_en, mem_space_en});
      wr(11'h010, 4'hF, 32'hABCDE123);
      rd(11'h010, 32'hABCDE008, "base");
      mem_req = 1'b1;
      mem_addr = 32'hABCDE7F0;
      watch(mem_hit, 2, hi);
      chk("hit inside", 32'h1, {31'h0, hi});
      mem_addr = 32'hABCDF000;
      watch(mem_hit, 2, hi);
      chk("hit outside", 32'h0, {31'h0, hi});
      mst_want = 1'b1;
      watch(bus_req, 2, hi);
      chk("bus request", 32'h1, {31'h0, hi});
      wr(11'h004, 4'h3, 32'h00000000);
      mem_addr = 32'hABCDE000;
      watch(mem_hit, 1, hi);
      watch(mem_hit, 3, hi);
      chk("hit disabled", 32'h0, {31'h0, hi});
      watch(bus_req, 3, hi);
      chk("req disabled", 32'h0, {31'h0, hi});
      mem_req = 1'b0;
      mst_want = 1'b0;
      rd(11'h004, 32'h02800000, "cmd zero still read");
      $display("test_command done");
   endtask : test_command

   // status events, write-one-to-clear and gated drives
   task automatic test_events();
      wr(11'h004, 4'h3, 32'h00000140);
      mst_read = 1'b1;
      fire(6'b010000, 3'b010, "read data parity");
      fire(6'b000001, 3'b100, "system error");
      fire(6'b001000, 3'b000, "master abort");
      fire(6'b000100, 3'b000, "target abort");
      fire(6'b100000, 3'b001, "address parity");
      rd(11'h004, 32'hFB800140, "all flags");
      wr(11'h004, 4'h4, 32'hFFFFFFFF);
      rd(11'h004, 32'hFB800140, "ro byte write");
      wr(11'h004, 4'h8, 32'h28000000);
      rd(11'h004, 32'hD3800140, "partial clear");
      wr(11'h004, 4'h8, 32'hFF000000);
      mst_read = 1'b0;
      fire(6'b000010, 3'b000, "target perr");
      rd(11'h004, 32'h03800140, "write parity seen");
      wr(11'h004, 4'hF, 32'hFF000000);
      mst_read = 1'b1;
      fire(6'b010001, 3'b000, "drives disabled");
      rd(11'h004, 32'h82800000, "parity no report");
      $display("test_events done");
   endtask : test_events

   // latency count and burst termination
   task automatic test_latency();
      logic hi;
      wr(11'h00C, 4'hF, 32'hFFFFFFFF);
      rd(11'h00C, 32'h0000FF00, "latency field");
      wr(11'h00C, 4'h2, 32'h00000200);
      mst_burst = 1'b1;
      mst_gnt_n = 1'b0;
      watch(lat_terminate, 8, hi);
      chk("grant held", 32'h0, {31'h0, hi});
      mst_gnt_n = 1'b1;
      watch(lat_terminate, 2, hi);
      chk("grant removed", 32'h1, {31'h0, hi});
      mst_burst = 1'b0;
      watch(lat_terminate, 1, hi);
      chk("burst ended", 32'h0, {31'h0, hi});
      watch(lat_terminate, 2, hi);
      mst_burst = 1'b1;
      watch(lat_terminate, 2, hi);
      chk("count running", 32'h0, {31'h0, hi});
      watch(lat_terminate, 5, hi);
      chk("count expired", 32'h1, {31'h0, hi});
      mst_burst = 1'b0;
      $display("test_latency done");
   endtask : test_latency

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // watchdog: the tests need well under a thousand cycles
   initial begin
      #(20 * 5000);
      n_fail++;
      report_and_stop();
   end

   // main sequence
   initial begin
      n_fail = 0;
      checks_done = 0;
      srst = 1'b1;
      evt = 6'h00;
      mem_req = 1'b0;
      mem_addr = 32'h00000000;
      mst_want = 1'b0;
      mst_burst = 1'b0;
      mst_gnt_n = 1'b1;
      mst_read = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      test_fixed();
      test_command();
      test_events();
      test_latency();
      report_and_stop();
   end
endmodule : pcicfg_header_regs_bench
